// ---- rx_params.svh ----
/*
 * Constants for the network output data receiver: block geometry per
 * protocol profile, indicator timing, port widths.
 * Assumes a 100 MHz clock; included by the package, whose macros the modules use.
 */
`ifndef RX_PARAMS_SVH
`define RX_PARAMS_SVH

// ----------------------------------------------------------------------
// data set geometry
// ----------------------------------------------------------------------
`define SET_BYTES        50
`define BLOCK_MAX_BYTES  12
`define NUM_BLOCKS       5
`define NUM_CONN         4
`define BLK_W            3
`define IDX_W            4
`define CONN_W           2
`define BLK_ETH_BYTES    4'hA
`define BLK_PB_BYTES     4'hC
`define BLK_PB_LAST      4'h2
`define BLK_CAN_BYTES    4'h8
`define BLK_CAN_COUNT    3'h4
`define BLK_FULL_COUNT   3'h5
`define BLK_LAST_IDX     3'h4

// ----------------------------------------------------------------------
// indicator timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS    10
`define FLASH_TIME_S     10
`define FLASH_HALF_MS    250
`define FLASH_CYCLES     (`FLASH_TIME_S * 64'd1000000000 / `CLK_PERIOD_NS)
`define HALF_CYCLES      (`FLASH_HALF_MS * 64'd1000000 / `CLK_PERIOD_NS)
`define CNT_W            30

`endif

// ---- rx_pkg.sv ----
/*
 * Types for the network output data receiver.
 * Assumes rx_params.svh is on the include path.
 */
`include "rx_params.svh"

package rx_pkg;

	typedef enum logic [1:0] {
		PROF_ETH  = 2'h0,
		PROF_PB   = 2'h1,
		PROF_CAN  = 2'h2
	} profile_t;

	typedef struct packed {
		logic                 valid;
		logic [`CONN_W-1:0]   conn;
		logic [`BLK_W-1:0]    blk;
		logic [`IDX_W-1:0]    idx;
		logic [7:0]           data;
	} net_byte_t;

	typedef struct packed {
		logic [`SET_BYTES*8-1:0] data;
		logic                    in_state;
		logic                    out_state;
	} rx_view_t;

	typedef enum logic [1:0] {
		LED_IDLE  = 2'h0,
		LED_RED   = 2'h1,
		LED_GREEN = 2'h3
	} led_state_t;

endpackage : rx_pkg

// ---- block_map.sv ----
/*
 * Maps a block number and byte index to a flat data set offset for the
 * active profile, and says whether the address exists.
 * Assumes profile is stable while bytes arrive.
 */
`timescale 1ns/100ps

module block_map
	import rx_pkg::*;
(
	// address in
	input  wire profile_t         i_profile,
	input  wire logic [`BLK_W-1:0] i_blk,
	input  wire logic [`IDX_W-1:0] i_idx,
	// mapped result
	output logic [5:0]             o_offset,
	output logic                   o_legal
);

	logic [3:0] size;
	logic [2:0] count;
	logic [5:0] base;

	always_comb begin
		unique case (i_profile)
			PROF_PB: begin
				size  = (i_blk == `BLK_LAST_IDX) ? `BLK_PB_LAST :
					`BLK_PB_BYTES;
				count = `BLK_FULL_COUNT;
				base  = 6'(i_blk * `BLK_PB_BYTES);
			end
			PROF_CAN: begin
				size  = `BLK_CAN_BYTES;
				count = `BLK_CAN_COUNT;
				base  = 6'(i_blk * `BLK_CAN_BYTES);
			end
			default: begin
				size  = `BLK_ETH_BYTES;
				count = `BLK_FULL_COUNT;
				base  = 6'(i_blk * `BLK_ETH_BYTES);
			end
		endcase
		o_legal  = (i_blk < count) && (i_idx < size);
		o_offset = 6'(base + 6'(i_idx));
	end

endmodule : block_map

// ---- net_out_rx.sv ----
/*
 * Network output data receiver: takes bytes of the output data set from
 * the network controller and presents tagged bits to the safety logic
 * and to second-gateway routing, with state bits and status indicator.
 * Assumes one clock, synchronous inputs, and that the network controller
 * reports per-connection up levels and one shared error and close event as levels/pulses.
 */
`timescale 1ns/100ps


module net_out_rx
	import rx_pkg::*;
(
	// clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_reset,
	// configuration
	input  wire profile_t                i_profile,
	input  wire logic [`SET_BYTES*8-1:0] i_tag_mask,
	// network side
	input  wire net_byte_t               i_byte,
	input  wire logic [`NUM_CONN-1:0]    i_conn_up,
	input  wire logic                    i_comm_error,
	input  wire logic                    i_conn_closed,
	input  wire logic                    i_tx_ok,
	// safety logic and routing side
	output rx_view_t                     o_logic,
	output rx_view_t                     o_route,
	output logic                         o_log_error,
	output led_state_t                   o_module_status_indicator
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [`SET_BYTES*8-1:0] data;
		logic                    in_state;
		logic                    out_state;
		logic [`CNT_W-1:0]       flash_cnt;
		logic [`CNT_W-1:0]       half_cnt;
		logic                    red;
		logic                    log_err;
		rx_view_t                view;
	} state_t;

	state_t q, d;

	logic [5:0] offset;
	logic       legal;
	logic       all_down;

	block_map u_map (
		.i_profile (i_profile),
		.i_blk     (i_byte.blk),
		.i_idx     (i_byte.idx),
		.o_offset  (offset),
		.o_legal   (legal)
	);

	assign all_down = ~|i_conn_up;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		d = q;
		d.log_err = 1'b0;
		// any connection may write; the last byte taken simply replaces
		if (i_byte.valid && legal) begin
			d.data[offset*8 +: 8] = i_byte.data;
			d.in_state = 1'b1;
		end
		d.out_state = i_tx_ok;
		if (i_comm_error) begin
			d.data      = '0;
			d.in_state  = 1'b0;
			d.out_state = 1'b0;
		end
		if (all_down) begin
			d.data     = '0;
			d.in_state = 1'b0;
		end
		// close of one link leaves state bits untouched
		if (i_conn_closed && !all_down) begin
			d.flash_cnt = `CNT_W'(`FLASH_CYCLES);
			d.half_cnt  = `CNT_W'(`HALF_CYCLES);
			d.red       = 1'b1;
			d.log_err   = 1'b1;
		end else if (q.flash_cnt != '0) begin
			d.flash_cnt = q.flash_cnt - 1'b1;
			if (q.half_cnt == `CNT_W'(1)) begin
				d.half_cnt = `CNT_W'(`HALF_CYCLES);
				d.red      = ~q.red;
			end else begin
				d.half_cnt = q.half_cnt - 1'b1;
			end
		end
		// untagged bits never leave the block
		d.view.data      = d.data & i_tag_mask;
		d.view.in_state  = d.in_state;
		d.view.out_state = d.out_state;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign o_logic     = q.view;
	assign o_route     = q.view;
	assign o_log_error = q.log_err;
	assign o_module_status_indicator = (q.flash_cnt == '0) ? LED_IDLE :
		(q.red ? LED_RED : LED_GREEN);

endmodule : net_out_rx

// ---- rx_monitor.sv ----
/* port checker for net_out_rx; bound to every instance, one clock */
`timescale 1ns/100ps
module rx_monitor
	import rx_pkg::*;
(
	input logic i_clk,
	input logic i_reset,
	input profile_t i_profile,
	input logic [399:0] i_tag_mask,
	input net_byte_t i_byte,
	input logic [3:0] i_conn_up,
	input logic i_comm_error,
	input logic i_conn_closed,
	input logic i_tx_ok,
	input rx_view_t o_logic,
	input rx_view_t o_route,
	input logic o_log_error,
	input led_state_t o_module_status_indicator
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	wire ok = !i_comm_error && |i_conn_up;
	wire zero_wr = ok && i_byte.valid && {i_byte.blk, i_byte.idx} == '0;
	route_copy_a: assert property (o_route == o_logic)
		else $error("route");
	mask_hide_a: assert property ((o_logic.data & ~i_tag_mask) == '0)
		else $error("mask");
	err_clear_a: assert property (i_comm_error |=> o_logic == '0)
		else $error("err");
	down_clear_a: assert property (i_conn_up == '0 |=>
		o_logic.data == '0 && !o_logic.in_state) else $error("down");
	tx_state_a: assert property (ok |=>
		o_logic.out_state == $past(i_tx_ok)) else $error("tx");
	close_flag_a: assert property (i_conn_closed && ok |=>
		o_log_error && o_module_status_indicator == LED_RED)
		else $error("close");
	first_byte_a: assert property (zero_wr |=> o_logic.in_state &&
		o_logic.data[7:0] == ($past(i_byte.data) & i_tag_mask[7:0]))
		else $error("write");
	can_fifth_a: assert property (ok && i_byte.valid &&
		i_byte.blk == 3'h4 && i_profile == PROF_CAN |=>
		$stable(o_logic.data)) else $error("can");
	cover property (zero_wr);
	cover property (i_conn_up == '0);
	cover property (i_conn_closed && ok);
endmodule : rx_monitor

bind net_out_rx rx_monitor mon_u (.*);

// ---- net_ctl.sv ----
/* network controller stand-in: one byte write per call of send */
`timescale 1ns/100ps
module net_ctl
	import rx_pkg::*;
(
	input logic i_clk,
	output net_byte_t o_byte
);
	initial o_byte = '0;
	task automatic send(logic [2:0] b, logic [3:0] x, logic [7:0] d);
		@(negedge i_clk);
		o_byte <= '{1'b1, b[1:0], b, x, d};
		@(negedge i_clk);
		// idle bus shows inverted fields, never the stale byte
		o_byte <= '{1'b0, ~b[1:0], ~b, ~x, ~d};
	endtask : send
endmodule : net_ctl

// ---- network_output_data_receiver_bench.sv ----
/* bench for net_out_rx: reference data set kept here; net_ctl sends */
`timescale 1ns/100ps
module network_output_data_receiver_bench
	import rx_pkg::*;
();
	logic i_clk, i_reset, i_comm_error, i_conn_closed, i_tx_ok;
	profile_t i_profile;
	logic [399:0] i_tag_mask, e_d;
	logic [3:0] i_conn_up;
	net_byte_t i_byte;
	rx_view_t o_logic, o_route;
	logic o_log_error, e_in;
	led_state_t o_module_status_indicator;
	logic [14:0] r;
	int n_mismatch = 0, n_tests = 0, seed = 34, p, k, sz;
	net_out_rx dut_u (.*);
	net_ctl ctl_u (.i_clk(i_clk), .o_byte(i_byte));
	initial begin
		i_clk = 0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		#200000;
		n_mismatch++;
		conclude;
	end
	task automatic chk(logic [399:0] dd, logic s, logic e, led_state_t l);
		n_tests++;
		if ({o_logic, o_log_error, o_module_status_indicator} !==
			{dd, s, i_tx_ok, e, l} || o_route !== o_logic) begin
			n_mismatch++;
			$display("mismatch at %0t: outputs", $time);
		end
	endtask : chk
	task automatic conclude;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude
	initial begin
		{i_reset, i_comm_error, i_conn_closed} = 3'h4;
		i_profile = PROF_ETH;
		i_conn_up = 4'hF;
		i_tx_ok = 1'($random(seed));
		for (k = 0; k < 50; k++)
			i_tag_mask[k*8 +: 8] = 8'($random(seed));
		repeat (8) @(negedge i_clk);
		i_reset = 0;
		for (p = 0; p < 3; p++) begin
			i_profile = profile_t'(p);
			i_comm_error = 1;
			{e_d, e_in} = '0;
			@(negedge i_clk);
			i_comm_error = 0;
			for (k = 0; k < 40; k++) begin
				r = k ? 15'($random(seed)) : 15'h0;
				sz = p == 0 ? 10 : p == 2 ? 8 : r[14:12] == 4 ? 2 : 12;
				if (r[14:12] < (p == 2 ? 4 : 5) && r[11:8] < sz) begin
					sz = r[14:12] * (p == 1 ? 12 : sz) + r[11:8];
					e_d[sz*8 +: 8] = r[7:0] & i_tag_mask[sz*8 +: 8];
					e_in = 1;
				end
				ctl_u.send(r[14:12], r[11:8], r[7:0]);
				chk(e_d, e_in, 0, LED_IDLE);
			end
		end
		i_conn_closed = 1;
		@(negedge i_clk);
		i_conn_closed = 0;
		chk(e_d, e_in, 1, LED_RED);
		i_conn_up = 4'h0;
		@(negedge i_clk);
		chk('0, 0, 0, LED_RED);
		conclude;
	end
endmodule : network_output_data_receiver_bench
